// >>> hw/srfc_defs.vh
// register offsets, field positions, reset values and response codes for srfc
// assumes plain verilog-2005 includes by bare name
`ifndef SRFC_DEFS_VH
`define SRFC_DEFS_VH
`define SRFC_OFF_RATE 4'h0
`define SRFC_OFF_FMT 4'h4
`define SRFC_OFF_CTRL 4'h8
`define SRFC_OFF_STAT 4'hC
`define SRFC_RATE_RESET 32'h00000000
`define SRFC_FMT_RESET 32'h88004400
`define SRFC_FMT_WMASK 32'hBFF07FFF
`define SRFC_RATE_WMASK 32'h000000FF
`define SRFC_SRC_MAX 4'h9
`define SRFC_FL_MIN 6'h08
`define SRFC_FL_MAX 6'h20
`define SRFC_CTRL_START 0
`define SRFC_CTRL_FIFO_LOAD 1
`define SRFC_STAT_BUSY 31
`define SRFC_RESP_OKAY 2'h0
`define SRFC_RESP_SLVERR 2'h2
`endif

// >>> hw/srfc_baud_gen.v
// baud generator: prescaler tap select then divide by 2*n
// assumes synchronous active-low reset and one clock domain
`default_nettype none
module srfc_baud_gen (
  input wire aclk,
  input wire aresetn,
  input wire [3:0] rate_source_select,
  input wire [3:0] rate_divisor,
  input wire run,
  output reg half_tick
);
  reg [8:0] pre_count;
  reg [4:0] div_count;
  reg tap_tick;
  wire [8:0] tap_len;
  wire [4:0] n_val;

  // tap k divides fc by 2**(k-1); taps 0 and 1 are fc itself
  assign tap_len = (rate_source_select == 4'h0) ? 9'h001 :
                   (9'h001 << (rate_source_select - 4'h1));
  assign n_val = (rate_divisor == 4'h0) ? 5'h10 : {1'b0, rate_divisor};

  //////////////////////////////////////////////////////////////////////
  // prescaler tap pulse
  always @(posedge aclk) begin
    if (!aresetn || !run) begin
      pre_count <= 9'h000;
      tap_tick <= 1'b0;
    end else if (pre_count >= tap_len - 9'h001) begin
      pre_count <= 9'h000;
      tap_tick <= 1'b1;
    end else begin
      pre_count <= pre_count + 9'h001;
      tap_tick <= 1'b0;
    end
  end

  // n taps per half period, so full period is 2*n taps
  always @(posedge aclk) begin
    if (!aresetn || !run) begin
      div_count <= 5'h00;
      half_tick <= 1'b0;
    end else begin
      half_tick <= 1'b0;
      if (tap_tick) begin
        if (div_count >= n_val - 5'h01) begin
          div_count <= 5'h00;
          half_tick <= 1'b1;
        end else begin
          div_count <= div_count + 5'h01;
        end
      end
    end
  end
endmodule // srfc_baud_gen
`default_nettype wire

// >>> hw/srfc_top.v
// serial rate and frame format control with a master-mode frame engine
// assumes axi4-lite master, synchronous active-low reset, 10 MHz aclk
//
// Summary of operation
// - source clock from ten prescaler taps
// - divisor code zero means sixteen
// - serial clock is source over 2n
// - bit order lsb or msb first
// - frame length 8 to 32 bits
// - burst gap of 0 to 15 clocks
// - idle clock level follows polarity bit
// - minimum deselect time 1 to 15 clocks
// - select to first edge code+1 clocks
// - end to deselect code+1 clocks
// - frame length change while idle discards fifo data
// - locked status zero only when idle
//
// Added by the designer: the register offsets and register access over AXI4-Lite.
`include "srfc_defs.vh"
`default_nettype none
module srfc_top (
  input wire aclk,
  input wire aresetn,
  input wire [31:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [31:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  output reg serial_clock_pin,
  output reg chip_select_out_pin,
  output reg serial_data_out,
  output reg fifo_discard
);
  localparam ST_IDLE = 3'h0;
  localparam ST_LEAD = 3'h1;
  localparam ST_SHIFT = 3'h2;
  localparam ST_GAP = 3'h3;
  localparam ST_LAG = 3'h4;
  localparam ST_DESEL = 3'h5;

  reg [31:0] serial_rate_select;
  reg [31:0] frame_format_control;
  reg [31:0] tx_word;
  reg [3:0] burst_left;
  reg fifo_has_data;
  reg [2:0] state;
  reg [5:0] bit_count;
  reg [4:0] wait_count;
  reg phase;
  reg aw_held;
  reg w_held;
  reg [3:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  wire half_tick;
  wire busy;
  wire do_write;
  wire [31:0] fmt_next;
  wire [5:0] frame_length;
  wire [3:0] burst_frame_gap;
  wire clock_idle_level;
  wire [3:0] select_idle_gap;
  wire [3:0] select_to_clock_lead;
  wire [3:0] clock_to_deselect_lag;
  wire msb_first;
  wire select_active_high;
  wire [5:0] frame_bits;
  wire [4:0] bit_index;
  wire start_now;
  wire frame_end;

  // field pick from the format register
  assign msb_first = frame_format_control[31];
  assign frame_length = frame_format_control[29:24];
  assign burst_frame_gap = frame_format_control[23:20];
  assign clock_idle_level = frame_format_control[14];
  assign select_idle_gap = frame_format_control[13:10];
  assign select_active_high = frame_format_control[8];
  assign select_to_clock_lead = frame_format_control[7:4];
  assign clock_to_deselect_lag = frame_format_control[3:0];
  assign busy = (state != ST_IDLE);

  // start decode also wakes the baud counters, saving a cycle of lead
  assign start_now = (state == ST_IDLE) && do_write && (aw_addr == `SRFC_OFF_CTRL) &&
                     w_data[`SRFC_CTRL_START];
  // last return-to-idle edge of a frame
  assign frame_end = (state == ST_SHIFT) && half_tick && phase &&
                     (bit_count == frame_bits - 6'h01);

  // prohibited lengths are clamped so the shifter never runs away
  assign frame_bits = (frame_length < `SRFC_FL_MIN) ? `SRFC_FL_MIN :
                      (frame_length > `SRFC_FL_MAX) ? `SRFC_FL_MAX :
                      frame_length;

  // position of the bit currently on the line
  assign bit_index = msb_first ? (frame_bits[4:0] - 5'h01 - bit_count[4:0]) :
                     bit_count[4:0];

  function [31:0] srfc_merge;
    input [31:0] old_val;
    input [31:0] new_val;
    input [3:0] strb;
    integer i;
    begin
      srfc_merge = old_val;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i]) begin
          srfc_merge[i*8 +: 8] = new_val[i*8 +: 8];
        end
      end
    end
  endfunction

  srfc_baud_gen u_baud (
    .aclk(aclk),
    .aresetn(aresetn),
    .rate_source_select(serial_rate_select[7:4]),
    .rate_divisor(serial_rate_select[3:0]),
    .run(busy || start_now),
    .half_tick(half_tick)
  );

  //////////////////////////////////////////////////////////////////////
  // axi4-lite write path: address and data taken in either order
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign do_write = aw_held && w_held && !s_axi_bvalid;
  assign fmt_next = (srfc_merge(frame_format_control, w_data, w_strb) &
                     `SRFC_FMT_WMASK);

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 4'h0;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `SRFC_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        // anything above the register window becomes a misaligned code
        aw_addr <= (s_axi_awaddr[31:4] == 28'h0000000) ? s_axi_awaddr[3:0] : 4'hF;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        // unmapped or misaligned writes answer slverr
        s_axi_bresp <= (aw_addr[1:0] == 2'h0 && aw_addr <= `SRFC_OFF_STAT) ?
                       `SRFC_RESP_OKAY : `SRFC_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // configuration registers; writes land even when busy, software checks lock
  always @(posedge aclk) begin
    if (!aresetn) begin
      serial_rate_select <= `SRFC_RATE_RESET;
      frame_format_control <= `SRFC_FMT_RESET;
      tx_word <= 32'h00000000;
      fifo_has_data <= 1'b0;
      burst_left <= 4'h0;
      fifo_discard <= 1'b0;
    end else begin
      fifo_discard <= 1'b0;
      if (do_write && aw_addr == `SRFC_OFF_RATE) begin
        serial_rate_select <= srfc_merge(serial_rate_select, w_data, w_strb) &
                              `SRFC_RATE_WMASK;
      end
      if (do_write && aw_addr == `SRFC_OFF_FMT) begin
        frame_format_control <= fmt_next;
        if (!busy && fifo_has_data && fmt_next[29:24] != frame_length) begin
          fifo_has_data <= 1'b0;
          fifo_discard <= 1'b1;
        end
      end
      // control: bit0 start burst of wdata[7:4]+1 frames, bit1 load word
      if (do_write && aw_addr == `SRFC_OFF_CTRL) begin
        if (w_data[`SRFC_CTRL_FIFO_LOAD]) begin
          fifo_has_data <= 1'b1;
        end
        if (w_data[`SRFC_CTRL_START] && !busy) begin
          burst_left <= w_data[7:4];
        end
      end
      if (do_write && aw_addr == `SRFC_OFF_STAT) begin
        tx_word <= srfc_merge(tx_word, w_data, w_strb);
      end
      // count frames as they end so the last one goes on to the lag
      if (frame_end && burst_left != 4'h0) begin
        burst_left <= burst_left - 4'h1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // axi4-lite read path, one cycle to rvalid
  assign s_axi_arready = !s_axi_rvalid;

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `SRFC_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `SRFC_RESP_OKAY;
      // addresses above the window fall into the error default
      case ((s_axi_araddr[31:4] == 28'h0000000) ? s_axi_araddr[3:0] : 4'hF)
        `SRFC_OFF_RATE: s_axi_rdata <= serial_rate_select;
        `SRFC_OFF_FMT: s_axi_rdata <= frame_format_control;
        `SRFC_OFF_CTRL: s_axi_rdata <= {28'h0000000, burst_left};
        `SRFC_OFF_STAT: s_axi_rdata <= {busy, 30'h00000000, fifo_has_data};
        default: begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= `SRFC_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // frame engine; two half ticks make one serial clock cycle
  always @(posedge aclk) begin
    if (!aresetn) begin
      state <= ST_IDLE;
      bit_count <= 6'h00;
      wait_count <= 5'h00;
      phase <= 1'b0;
      serial_clock_pin <= 1'b1;
      chip_select_out_pin <= 1'b1;
      serial_data_out <= 1'b0;
    end else begin
      case (state)
        ST_IDLE: begin
          serial_clock_pin <= clock_idle_level;
          chip_select_out_pin <= !select_active_high;
          phase <= 1'b0;
          if (do_write && aw_addr == `SRFC_OFF_CTRL &&
              w_data[`SRFC_CTRL_START]) begin
            state <= ST_LEAD;
            chip_select_out_pin <= select_active_high;
            wait_count <= {1'b0, select_to_clock_lead};
            bit_count <= 6'h00;
          end
        end
        ST_LEAD: begin
          serial_data_out <= tx_word[bit_index];
          // hand over one half period early: the first shift tick is the edge
          if (half_tick) begin
            if (phase) begin
              phase <= 1'b0;
              wait_count <= wait_count - 5'h01;
            end else if (wait_count == 5'h00) begin
              state <= ST_SHIFT;
            end else begin
              phase <= 1'b1;
            end
          end
        end
        ST_SHIFT: begin
          // data moves while the clock sits at idle, or with the leading edge at one tick per cycle
          if (!phase) begin
            serial_data_out <= tx_word[bit_index];
          end
          if (half_tick) begin
            serial_clock_pin <= !serial_clock_pin;
            phase <= !phase;
            if (phase) begin
              if (bit_count == frame_bits - 6'h01) begin
                bit_count <= 6'h00;
                // a zero gap simply stays here for the next frame
                if (burst_left == 4'h0) begin
                  state <= ST_LAG;
                  wait_count <= {1'b0, clock_to_deselect_lag};
                end else if (burst_frame_gap != 4'h0) begin
                  state <= ST_GAP;
                  wait_count <= {1'b0, burst_frame_gap};
                end
              end else begin
                bit_count <= bit_count + 6'h01;
              end
            end
          end
        end
        ST_GAP: begin
          serial_clock_pin <= clock_idle_level;
          if (half_tick) begin
            phase <= !phase;
            if (phase) begin
              wait_count <= wait_count - 5'h01;
              // leave on the last gap period so the next edge is on time
              if (wait_count == 5'h01) begin
                state <= ST_SHIFT;
              end
            end
          end
        end
        ST_LAG: begin
          serial_clock_pin <= clock_idle_level;
          if (half_tick) begin
            phase <= !phase;
            if (phase) begin
              if (wait_count == 5'h00) begin
                state <= ST_DESEL;
                chip_select_out_pin <= !select_active_high;
                // code 0 is prohibited; treat it as one cycle
                wait_count <= (select_idle_gap == 4'h0) ? 5'h01 :
                              {1'b0, select_idle_gap};
              end else begin
                wait_count <= wait_count - 5'h01;
              end
            end
          end
        end
        ST_DESEL: begin
          if (half_tick) begin
            phase <= !phase;
            if (phase) begin
              wait_count <= wait_count - 5'h01;
              if (wait_count == 5'h01) begin
                state <= ST_IDLE;
              end
            end
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end
endmodule // srfc_top
`default_nettype wire

// >>> dv/srfc_periph_model.sv
// far-side peripheral: times clock and select, shifts in data
// assumes active-low select, data steady on the return-to-idle edge
`default_nettype none
module srfc_periph_model (
  input wire logic aclk,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic sdo,
  input wire logic idle_lvl,
  output logic [31:0] rx_word,
  output int edges,
  output int lead,
  output int half,
  output int lag,
  output int big,
  output int desel
);
  timeunit 1ns;
  timeprecision 1ns;
  logic ps = 1'b1;
  logic pc = 1'b1;
  int cnt = 0;
  ////////////////////////////////////////////////////////////////////
  // counts in aclk cycles since the last pin event
  always @(posedge aclk) begin
    ps <= sclk;
    pc <= cs_n;
    cnt <= cnt + 1;
    if (pc && !cs_n) begin
      desel <= cnt;
      cnt <= 1;
      edges <= 0;
      big <= 0;
      rx_word <= '0;
    end else if (!pc && cs_n) begin
      lag <= cnt;
      cnt <= 1;
    end else if (!cs_n && sclk != ps) begin
      edges <= edges + 1;
      cnt <= 1;
      if (edges == 0) lead <= cnt;
      if (edges == 1) half <= cnt;
      if (edges > 0 && cnt > big) big <= cnt;
      // at least half a period after launch, so data has settled
      if (sclk == idle_lvl) rx_word <= {rx_word[30:0], sdo};
    end
  end
endmodule // srfc_periph_model
`default_nettype wire

// >>> dv/srfc_asserts.sv
// checker: bus handshake and select timing of srfc_top
// assumes select polarity stays at its reset value, active low
`default_nettype none
module srfc_asserts (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic serial_clock_pin,
  input wire logic chip_select_out_pin,
  input wire logic fifo_discard
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////////////////////////////////
  // both halves of a write taken at one edge
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  // lead is at least one serial period, two aclk cycles
  sequence s_clk_quiet;
    $stable(serial_clock_pin) [*2];
  endsequence
  // answer is registered the cycle after both halves are held
  a_write_answer: assert property (s_wr_taken |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
  a_lead_quiet: assert property (
    $fell(chip_select_out_pin) |-> s_clk_quiet) else $error("clock during lead");
  a_lag_quiet: assert property (
    $rose(chip_select_out_pin) |-> $stable(serial_clock_pin)) else $error("clock at deselect");
  a_discard_pulse: assert property (fifo_discard |=> !fifo_discard)
    else $error("discard too long");
  a_discard_idle: assert property (fifo_discard |-> chip_select_out_pin)
    else $error("discard while busy");
endmodule // srfc_asserts
bind srfc_top srfc_asserts u_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .serial_clock_pin,
  .chip_select_out_pin, .fifo_discard);
`default_nettype wire

// >>> dv/tb_top.sv
// bench: programs srfc_top over axi4-lite and times its serial pins
// assumes the peripheral model and the checker are compiled first
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {logic [31:0] rate, fmt, word; int half;} srfc_row_t;
  srfc_row_t rows [4] = '{'{32'h01, 32'h88004400, 32'hA5, 1},
    '{32'h10, 32'h20000432, 32'h1234ABCD, 16}, '{32'h23, 32'h8D0044FF, 32'h1F35, 6},
    '{32'h92, 32'h88004400, 32'h5A, 512}};
  logic aclk = 1'b0, aresetn = 1'b0, lvl = 1'b1, disc = 1'b0;
  logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata, rx;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, sclk, csn, sdo, disc_p;
  logic [1:0] bresp, rresp;
  int edges, lead, half, lag, big, desel, errors = 0, cmp_count = 0;
  srfc_top u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .serial_clock_pin(sclk), .chip_select_out_pin(csn), .serial_data_out(sdo),
    .fifo_discard(disc_p));
  srfc_periph_model u_peer (.aclk(aclk), .sclk(sclk), .cs_n(csn), .sdo(sdo), .idle_lvl(lvl),
    .rx_word(rx), .edges(edges), .lead(lead), .half(half), .lag(lag), .big(big),
    .desel(desel));
  ////////////////////////////////////////////////////////////////////
  // 10 MHz clock
  always #50 aclk = ~aclk;
  // latch the one-cycle discard pulse so a later read can see it
  always @(posedge aclk) if (disc_p) disc <= 1'b1;
  task automatic chk(input logic [31:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("errors %0d compares %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // ready is sampled mid-cycle, so the edge that takes it is known
  task automatic axi_wr(input logic [31:0] a, d, output logic [1:0] r);
    logic pa, pw, sa, sw, sb;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    pa = 1'b1;
    pw = 1'b1;
    do begin
      @(negedge aclk);
      sa = awready;
      sw = wready;
      sb = bvalid;
      r = bresp;
      @(posedge aclk);
      if (pa && sa) begin
        awvalid <= 1'b0;
        pa = 1'b0;
      end
      if (pw && sw) begin
        wvalid <= 1'b0;
        pw = 1'b0;
      end
    end while (sb !== 1'b1);
    bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    logic p, sa, sv;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    p = 1'b1;
    do begin
      @(negedge aclk);
      sa = arready;
      sv = rvalid;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (p && sa) begin
        arvalid <= 1'b0;
        p = 1'b0;
      end
    end while (sv !== 1'b1);
    rready <= 1'b0;
  endtask
  task automatic wr(input logic [31:0] a, d);
    logic [1:0] r;
    axi_wr(a, d, r);
    chk(r, 2'h0);
  endtask
  // program, start, then poll the busy bit until the frame is over
  task automatic frame(input logic [31:0] rate, fmt, word, input logic [3:0] extra);
    logic [31:0] d;
    logic [1:0] r;
    int n;
    lvl <= fmt[14];
    wr(32'h0, rate);
    wr(32'h4, fmt);
    wr(32'hC, word);
    wr(32'h8, {24'h0, extra, 4'h1});
    axi_rd(32'hC, d, r);
    chk(d[31], 1'b1);
    n = 0;
    while (d[31] !== 1'b0 && n < 20000) begin
      axi_rd(32'hC, d, r);
      n++;
    end
    chk(d[31], 1'b0);
    chk(csn, 1'b1);
  endtask
  function automatic logic [31:0] want_word(logic [31:0] w, logic [5:0] fl, logic msb);
    logic [31:0] e;
    e = '0;
    for (int i = 0; i < fl; i++) e[i] = msb ? w[i] : w[fl - 1 - i];
    return e;
  endfunction
  // register stages may shift an edge by up to half a period
  function automatic logic near(int v, int e, int h);
    return v >= e - h && v <= e + h;
  endfunction
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    int h;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk(sclk, 1'b1);
    chk(csn, 1'b1);
    axi_rd(32'h0, d, r);
    chk(d, 32'h0);
    axi_rd(32'h4, d, r);
    chk(d, 32'h88004400);
    foreach (rows[i]) begin
      frame(rows[i].rate, rows[i].fmt, rows[i].word, 4'h0);
      h = rows[i].half;
      chk(edges, 2 * rows[i].fmt[29:24]);
      chk(half, h);
      chk(near(lead, 2 * h * (rows[i].fmt[7:4] + 1), h), 1'b1);
      chk(near(lag, 2 * h * (rows[i].fmt[3:0] + 1), h), 1'b1);
      chk(rx, want_word(rows[i].word, rows[i].fmt[29:24], rows[i].fmt[31]));
      chk(sclk, rows[i].fmt[14]);
    end
    wr(32'h0, 32'hFFFFFFFF);
    axi_rd(32'h0, d, r);
    chk(d, 32'h000000FF);
    // unmapped word answers with an error and zero data
    axi_rd(32'h10, d, r);
    chk(d, 32'h0);
    chk(r, 2'h2);
    axi_wr(32'h10, 32'h1, r);
    chk(r, 2'h2);
    // two-frame burst with a three-clock gap
    frame(32'h01, 32'h88304400, 32'hC3, 4'h1);
    chk(edges, 32);
    chk(near(big, 7, 1), 1'b1);
    // back-to-back starts must still wait out the deselect time
    frame(32'h01, 32'h88007C00, 32'h3C, 4'h0);
    frame(32'h01, 32'h88007C00, 32'h3C, 4'h0);
    chk(desel >= 30, 1'b1);
    // held word survives an unchanged length, dropped on a change
    wr(32'h8, 32'h2);
    disc <= 1'b0;
    wr(32'h4, 32'h88004400);
    axi_rd(32'hC, d, r);
    chk({disc, d[0]}, 2'b01);
    wr(32'h4, 32'h89004400);
    axi_rd(32'hC, d, r);
    chk({disc, d[0]}, 2'b10);
    test_done();
  end
  // hang guard, well past the slowest frame
  initial begin
    repeat (80000) @(posedge aclk);
    errors++;
    test_done();
  end
endmodule // tb_top
`default_nettype wire
